// ### design/chfp_pkg.sv
// constants shared by the configuration host/flash port
package chfp_pkg;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned SEL_W       = 4;
  localparam int unsigned STRAP_W     = 3;
  localparam int unsigned STRAP_TEST  = 0;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SCK_HZ      = 5_000_000;
  // half period of the flash serial clock in system cycles
  localparam int unsigned SCK_HALF    = CLK_HZ / (2 * SCK_HZ);
  localparam int unsigned DIV_W       = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF - 1);
  localparam logic [SEL_W-1:0] SEL_NONE = 4'hF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // port mode, one-hot
  typedef enum logic [2:0] {
    CHFP_IDLE  = 3'b001,
    CHFP_HOST  = 3'b010,
    CHFP_FLASH = 3'b100
  } chfp_mode_t;
endpackage

// ### design/chfp_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module chfp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### design/chfp_port.sv
// shared host/flash loading port of the configuration unit
// Behaviour
// R1 - in flash mode the port makes the flash serial clock itself by dividing its own clock.
// R2 - the port can pause a flash transfer with the low-active pause line, timed to the serial clock.
// R3 - four low-active flash selects; single mode uses bit 0, quad mode drives one per device.
// R4 - the shared 32-bit bus belongs to only one mode at a time.
// R5 - host-mode transfers are sampled on edges of the host-supplied clock.
// R6 - the host selects the port by pulling the select low; high means deselected.
// R7 - read-back valid is high exactly in the host cycles that carry read-back data.
// R8 - status outputs come straight from registers reset to zero and rise cleanly.
// R9 - no assumption is made about the first edge of the host clock.
// R10 - the bus is released whenever no read-back data is driven.
// R11 - with test strap bit 0 high the host select is gated off.
`timescale 1ns/1ps
`default_nettype none
module chfp_port
(
  input  wire logic                      clk_sys_i,
  input  wire logic                      rst_n_i,
  // pins
  input  wire logic                      host_clk_i,
  input  wire logic                      host_port_select_n_i,
  input  wire logic [chfp_pkg::STRAP_W-1:0] test_strap_i,
  input  wire logic [chfp_pkg::DATA_W-1:0]  dq_i,
  output logic      [chfp_pkg::DATA_W-1:0]  dq_o,
  output logic      [chfp_pkg::DATA_W-1:0]  dq_oe_n_o,
  output logic                           dq_valid_o,
  output logic                           flash_sck_o,
  output logic                           flash_pause_n_o,
  output logic      [chfp_pkg::SEL_W-1:0]   flash_select_n_o,
  // core side
  input  wire logic                      flash_mode_i,
  input  wire logic                      flash_quad_i,
  input  wire logic [1:0]                flash_dev_i,
  input  wire logic                      flash_start_i,
  input  wire logic                      flash_stop_i,
  input  wire logic                      flash_pause_req_i,
  input  wire logic                      rb_valid_i,
  input  wire logic [chfp_pkg::DATA_W-1:0]  rb_data_i,
  output logic                           rb_taken_o,
  output logic                           wr_valid_o,
  output logic      [chfp_pkg::DATA_W-1:0]  wr_data_o,
  output logic                           host_active_o,
  output logic                           flash_active_o
);
  import chfp_pkg::*;

  // synchronised pin levels
  logic                 hclk_s;
  logic                 hsel_n_s;
  logic [STRAP_W-1:0]   strap_s;
  logic [DATA_W-1:0]    dq_s;

  chfp_sync #(.W(2 + STRAP_W)) u_sync_ctl (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({host_clk_i, host_port_select_n_i, test_strap_i}),
    .sync_o    ({hclk_s, hsel_n_s, strap_s})
  );

  chfp_sync #(.W(DATA_W)) u_sync_dq (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (dq_i),
    .sync_o    (dq_s)
  );

  // registers
  chfp_mode_t           mode_q;
  chfp_mode_t           mode_d;
  logic                 hclk_q;
  logic [DIV_W-1:0]     div_q;
  logic                 sck_q;
  logic                 pause_n_q;
  logic [SEL_W-1:0]     sel_n_q;
  logic [DATA_W-1:0]    dq_q;
  logic [DATA_W-1:0]    oe_n_q;
  logic                 valid_q;
  logic                 taken_q;
  logic                 wr_valid_q;
  logic [DATA_W-1:0]    wr_data_q;
  logic                 host_act_q;
  logic                 flash_act_q;
  logic [1:0]           fill_q;

  // host select counts only in functional strap mode
  wire host_sel   = !hsel_n_s && !strap_s[STRAP_TEST];   // see R6, see R11
  // edges count only once synchroniser and edge flop both hold real
  // pin levels, so the host clock may start high or low
  wire hclk_rise  = hclk_s && !hclk_q && (&fill_q);      // see R5, see R9
  wire div_wrap   = (div_q == DIV_LAST);
  wire sck_fall   = div_wrap && sck_q;
  wire in_host    = (mode_q == CHFP_HOST);
  wire in_flash   = (mode_q == CHFP_FLASH);
  wire drive_rb   = in_host && hclk_rise && rb_valid_i;
  wire [SEL_W-1:0] sel_onehot = SEL_W'(1) << flash_dev_i;
  // single mode always uses select 0
  wire [SEL_W-1:0] sel_pick  = flash_quad_i ? ~sel_onehot : 4'hE; // see R3

  // mode arbitration; one owner of the bus at a time
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      CHFP_IDLE: begin
        if (flash_mode_i && flash_start_i) begin
          mode_d = CHFP_FLASH;
        end else if (!flash_mode_i && host_sel) begin
          mode_d = CHFP_HOST;
        end
      end
      CHFP_HOST: begin
        if (!host_sel) begin
          mode_d = CHFP_IDLE;                              // see R4
        end
      end
      CHFP_FLASH: begin
        if (flash_stop_i && sck_fall) begin
          mode_d = CHFP_IDLE;                              // see R4
        end
      end
      default: begin
        mode_d = CHFP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q      <= CHFP_IDLE;
      hclk_q      <= 1'b0;
      fill_q      <= 2'h0;
    end else begin
      mode_q      <= mode_d;
      hclk_q      <= hclk_s;
      if (!(&fill_q)) begin
        fill_q <= fill_q + 2'h1;                           // see R9
      end
    end
  end

  // serial clock divider, runs only while flash owns the port
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      sck_q <= 1'b0;
    end else if (in_flash) begin
      div_q <= div_wrap ? '0 : div_q + 1'b1;
      if (div_wrap) begin
        sck_q <= !sck_q;                                   // see R1
      end
    end else begin
      div_q <= '0;
      sck_q <= 1'b0;
    end
  end

  // pause and selects change only while the serial clock is low,
  // so the flash samples them cleanly on the next rising edge
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pause_n_q <= 1'b1;
      sel_n_q   <= SEL_NONE;
    end else if (!in_flash) begin
      pause_n_q <= 1'b1;
      sel_n_q   <= SEL_NONE;
    end else if (sel_n_q == SEL_NONE) begin
      // selects drop on entry; pause waits for a serial clock fall
      sel_n_q   <= sel_pick;                               // see R3
    end else if (sck_fall) begin
      // a stop always leaves the flash out of pause
      pause_n_q <= !(flash_pause_req_i && !flash_stop_i);  // see R2
      sel_n_q   <= sel_pick;                               // see R3
    end
  end

  // host read-back drive and write capture on host clock edges
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_q       <= DATA_ZERO;
      oe_n_q     <= '1;
      valid_q    <= 1'b0;
      taken_q    <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_data_q  <= DATA_ZERO;
    end else begin
      taken_q    <= drive_rb;
      wr_valid_q <= 1'b0;
      if (!in_host) begin
        oe_n_q  <= '1;                                     // see R4, see R10
        valid_q <= 1'b0;
      end else if (hclk_rise) begin
        valid_q <= rb_valid_i;                             // see R7
        oe_n_q  <= rb_valid_i ? '0 : '1;                   // see R10
        dq_q    <= rb_valid_i ? rb_data_i : DATA_ZERO;
        if (!rb_valid_i && oe_n_q[0]) begin
          wr_valid_q <= 1'b1;                              // see R5
          wr_data_q  <= dq_s;
        end
      end
    end
  end

  // status flags, registered and zero from reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_act_q  <= 1'b0;
      flash_act_q <= 1'b0;
    end else begin
      host_act_q  <= in_host;                              // see R8
      flash_act_q <= in_flash;                             // see R8
    end
  end

  assign dq_o             = dq_q;
  assign dq_oe_n_o        = oe_n_q;
  assign dq_valid_o       = valid_q;
  assign flash_sck_o      = sck_q;
  assign flash_pause_n_o  = pause_n_q;
  assign flash_select_n_o = sel_n_q;
  assign rb_taken_o       = taken_q;
  assign wr_valid_o       = wr_valid_q;
  assign wr_data_o        = wr_data_q;
  assign host_active_o    = host_act_q;
  assign flash_active_o   = flash_act_q;
endmodule
`default_nettype wire

// ### sim/chfp_port_monitor.sv
// pin checker for the host/flash port
`timescale 1ns/1ps
`default_nettype none
module chfp_port_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        rb_valid_i,
  input wire logic [31:0] dq_oe_n_o,
  input wire logic        dq_valid_o,
  input wire logic        flash_sck_o,
  input wire logic        flash_pause_n_o,
  input wire logic [3:0]  flash_select_n_o,
  input wire logic        rb_taken_o,
  input wire logic        wr_valid_o,
  input wire logic        host_active_o,
  input wire logic        flash_active_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_high; flash_sck_o [*4] ##1 !flash_sck_o; endsequence
  property p_src; $rose(flash_sck_o) |-> flash_active_o; endproperty
  a_src: assert property (p_src) else $error("sck outside flash");
  property p_half; $rose(flash_sck_o) |-> s_high; endproperty
  a_half: assert property (p_half) else $error("sck half period");
  property p_pause; $changed(flash_pause_n_o) |-> $fell(flash_sck_o); endproperty
  a_pause: assert property (p_pause) else $error("pause off sck fall");
  property p_sel; $countones(~flash_select_n_o) <= 1; endproperty
  a_sel: assert property (p_sel) else $error("two selects low");
  property p_excl; !(host_active_o && flash_active_o); endproperty
  a_excl: assert property (p_excl) else $error("both modes");
  property p_rel; dq_valid_o ? dq_oe_n_o == 32'h0 : dq_oe_n_o == 32'hFFFF_FFFF; endproperty
  a_rel: assert property (p_rel) else $error("bus enable");
  property p_rd; rb_taken_o |-> $past(rb_valid_i) && dq_valid_o && host_active_o; endproperty
  a_rd: assert property (p_rd) else $error("read-back valid");
  property p_rdv; $rose(dq_valid_o) |-> rb_taken_o; endproperty
  a_rdv: assert property (p_rdv) else $error("valid without word");
  property p_wr; wr_valid_o |-> !$past(rb_valid_i) && !dq_valid_o; endproperty
  a_wr: assert property (p_wr) else $error("write capture");
endmodule
bind chfp_port chfp_port_monitor mon (.*);
`default_nettype wire

// ### sim/chfp_host_model.sv
// host processor model: clocks the port and drives write words
`timescale 1ns/1ps
`default_nettype none
module chfp_host_model (
  input  wire logic        clk_sys_i,
  input  wire logic        run_i,
  output logic             host_clk_o = 1'h1,
  output logic [31:0]      host_dq_o = 32'hC3A5_0000
);
  logic [1:0] ph_q = 2'h0;
  // idles high so the first edge is a fall; data moves at falls, settled at rises
  always @(negedge clk_sys_i) begin
    ph_q <= run_i ? ph_q + 2'h1 : 2'h0;
    host_clk_o <= !run_i || (host_clk_o ^ (ph_q == 2'h3));
    if (run_i && ph_q == 2'h3 && host_clk_o) host_dq_o <= host_dq_o + 32'h0101_0001;
  end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// bench for the host/flash port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed { logic rd; logic [31:0] d; } chfp_row_t;
  logic clk_sys_i = 1'h0, rst_n_i = 1'h0, host_run = 1'h0, host_clk_i, rb_valid_i = 1'h0;
  logic host_port_select_n_i = 1'h0, flash_mode_i = 1'h0, flash_quad_i = 1'h0;
  logic flash_start_i = 1'h0, flash_stop_i = 1'h0, flash_pause_req_i = 1'h0;
  logic [1:0] flash_dev_i = 2'h2;
  logic [2:0] test_strap_i = 3'h1;
  logic [31:0] rb_data_i = 32'h0, dq_i, dq_o, dq_oe_n_o, wr_data_o, host_dq, exp_w;
  logic dq_valid_o, flash_sck_o, flash_pause_n_o, rb_taken_o, wr_valid_o;
  logic host_active_o, flash_active_o;
  logic [3:0] flash_select_n_o;
  int fail_count = 0, checked = 0;
  chfp_row_t rows [3] = '{'{1'h1, 32'hDEAD_0001}, '{1'h0, 32'h0}, '{1'h1, 32'h0000_FFFF}};
  // bits whose enable is low come from the port, the rest from the host
  assign dq_i = (dq_o & ~dq_oe_n_o) | (host_dq & dq_oe_n_o);
  always @(posedge host_clk_i) exp_w <= host_dq;
  chfp_port dut (.*);
  chfp_host_model host (.clk_sys_i(clk_sys_i), .run_i(host_run), .host_clk_o(host_clk_i),
                        .host_dq_o(host_dq));
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: %h versus %h", $time, g, e);
    end
  endtask
  // bounded wait, looked at on falling edges where outputs are settled
  task automatic wait_v(ref logic s, input logic v);
    int n;
    n = 0;
    do @(negedge clk_sys_i); while (s !== v && ++n < 400);
    if (s !== v) begin
      fail_count++;
      $display("unexpected at %0t: %h versus %h", $time, s, v);
    end
  endtask
  task automatic close_out();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk_sys_i);
    chk({flash_sck_o, flash_pause_n_o, dq_valid_o, host_active_o, flash_active_o, rb_taken_o,
         wr_valid_o, flash_select_n_o, dq_oe_n_o[20:0]}, 32'h41FF_FFFF);
    rst_n_i = 1'h1;
    host_run = 1'h1;
    // strap bit 0 high keeps the select from the port
    repeat (40) @(negedge clk_sys_i);
    chk({30'h0, host_active_o, flash_active_o}, 32'h0);
    test_strap_i = 3'h0;
    wait_v(host_active_o, 1'h1);
    foreach (rows[i]) begin
      rb_valid_i = rows[i].rd;
      rb_data_i = rows[i].d;
      if (rows[i].rd) wait_v(rb_taken_o, 1'h1);
      else wait_v(wr_valid_o, 1'h1);
      chk(rows[i].rd ? dq_o : wr_data_o, rows[i].rd ? rows[i].d : exp_w);
    end
    rb_valid_i = 1'h0;
    host_port_select_n_i = 1'h1;
    host_run = 1'h0;
    wait_v(host_active_o, 1'h0);
    flash_mode_i = 1'h1;
    // single then quad session, each paused and then stopped
    for (int k = 0; k < 2; k++) begin
      flash_quad_i = k[0];
      flash_start_i = 1'h1;
      wait_v(flash_active_o, 1'h1);
      flash_start_i = 1'h0;
      flash_pause_req_i = 1'h1;
      repeat (24) @(negedge clk_sys_i);
      chk({27'h0, flash_pause_n_o, flash_select_n_o}, k ? 32'hB : 32'hE);
      flash_pause_req_i = 1'h0;
      flash_stop_i = 1'h1;
      wait_v(flash_active_o, 1'h0);
      flash_stop_i = 1'h0;
      repeat (4) @(negedge clk_sys_i);
      chk({27'h0, flash_sck_o, flash_select_n_o}, 32'hF);
    end
    close_out();
  end
  // whole run is about two hundred cycles
  initial begin
    #300us;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
